// File: rtl/lsd_cost.sv
// cycle cost of each decoded form, for both bus variants
// assumes a stable decoded form and bus-variant level at its inputs
`timescale 1ns/1ps
module lsd_cost
    import lsd_pkg::*;
(
    input wire lsd_dec_t dec,
    input wire logic narrow_bus,
    output lsd_cost_t cost
);
    logic [1:0] xfer;
    logic [7:0] add;
    logic mem;
    always_comb begin
        cost = '0;
        xfer = 2'h0;
        mem = dec.mem && !dec.acc;
        case (dec.op)
            LSD_AND, LSD_OR, LSD_XOR: begin
                if (dec.grp == G_IMM) begin
                    cost.ovh = mem ? CY_IMM_MEM : CY_IMM_REG;
                end else begin
                    cost.ovh = mem ? CY_LOG_MEM : CY_LOG_REG;
                end
                xfer = mem ? 2'h2 : 2'h0;
            end
            LSD_NOT: begin
                cost.ovh = mem ? CY_LOG_MEM : CY_LOG_REG;
                xfer = mem ? 2'h2 : 2'h0;
            end
            LSD_TEST: begin
                if (dec.acc) begin
                    cost.ovh = dec.wide ? CY_ACC_W : CY_ACC_B;
                end else if (dec.grp == G_GRP3) begin
                    cost.ovh = mem ? CY_TI_MEM : CY_TI_REG;
                end else begin
                    cost.ovh = mem ? CY_LOG_MEM : CY_LOG_REG;
                end
                xfer = mem ? 2'h1 : 2'h0;
            end
            LSD_MOVE: begin
                cost.ovh = dec.rpt ? CY_RMOV_O : 8'h00;
                cost.elem = dec.rpt ? CY_RMOV_E : CY_MOVE;
                xfer = 2'h2;
            end
            LSD_CMP: begin
                cost.ovh = dec.rpt ? CY_RCMP_O : 8'h00;
                cost.elem = dec.rpt ? CY_RCMP_E : CY_CMP;
                xfer = 2'h2;
            end
            LSD_SCAN: begin
                cost.ovh = dec.rpt ? CY_RSCN_O : 8'h00;
                cost.elem = dec.rpt ? CY_RSCN_E : CY_SCAN;
                xfer = 2'h1;
            end
            LSD_LOAD: begin
                cost.ovh = dec.rpt ? CY_RLD_O : 8'h00;
                cost.elem = dec.rpt ? CY_RLD_E : CY_LOAD;
                xfer = 2'h1;
            end
            LSD_STORE: begin
                cost.ovh = dec.rpt ? CY_RST_O : 8'h00;
                cost.elem = dec.rpt ? CY_RST_E : CY_STORE;
                xfer = 2'h1;
            end
            LSD_PIN, LSD_POUT: begin
                cost.ovh = dec.rpt ? CY_RMOV_O : 8'h00;
                cost.elem = dec.rpt ? CY_RMOV_E : CY_PORT;
                xfer = 2'h1;
            end
            default: begin
                cost = '0;
            end
        endcase
        // byte figures stand as base; word ops on the narrow bus pay per transfer
        add = (narrow_bus && dec.wide) ? 8'(8'(xfer) * CY_WORD_XFER) : 8'h00;
        if (cost.elem != 8'h00) begin
            cost.elem = 8'(cost.elem + add);
        end else begin
            cost.ovh = 8'(cost.ovh + add);
        end
    end
endmodule

// File: rtl/lsd_decoder.sv
// decoder and sequencer for bitwise logic and string instructions
// assumes opcode bytes from fetch logic on core_clk and a bus-variant strap pin
`timescale 1ns/1ps
module lsd_decoder
    import lsd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic narrow_bus_pin,
    input wire logic dir_flag,
    input wire logic equal_in,
    input wire logic [15:0] count_in,
    input wire logic [15:0] src_in,
    input wire logic [15:0] dst_in,
    output logic byte_ready_q,
    output lsd_dec_t dec_q,
    output logic [15:0] imm_q,
    output logic busy_q,
    output logic done_q,
    output logic wr_back_q,
    output logic flags_upd_q,
    output logic elem_q,
    output logic bad_op_q,
    output logic [15:0] src_q,
    output logic [15:0] dst_q,
    output logic [15:0] count_q
);
    lsd_state_t st_q, st_d;
    lsd_dec_t dec_d;
    lsd_cost_t cost;
    logic [15:0] imm_d, src_d, dst_d, count_d, step;
    logic [7:0] cnt_q, cnt_d;
    logic pend_q, pend_d, bad_d, take, last, narrow_s, cmp_scan;
    logic busy_d, done_d, wr_d, flg_d, elem_d, elem_end, uses_src, uses_dst;
    lsd_op_t op_str;

    lsd_sync2 u_lsd_sync2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(narrow_bus_pin),
        .level_q(narrow_s)
    );

    lsd_cost u_lsd_cost (
        .dec(dec_d),
        .narrow_bus(narrow_s),
        .cost(cost)
    );

    assign take = byte_valid && byte_ready_q;
    assign cmp_scan = (dec_q.op == LSD_CMP) || (dec_q.op == LSD_SCAN);
    assign elem_end = (st_q == S_ELEM) && (cnt_q == CNT_ONE);
    // while-equal stops on unequal, while-unequal stops on equal
    assign last = (count_q == 16'h0001) || (dec_q.rpt && cmp_scan && (equal_in != dec_q.rpt_z));

    always_comb begin
        case (byte_data[7:1])
            OP_MOVE: op_str = LSD_MOVE;
            OP_CMP: op_str = LSD_CMP;
            OP_SCAN: op_str = LSD_SCAN;
            OP_LOAD: op_str = LSD_LOAD;
            OP_STORE: op_str = LSD_STORE;
            OP_PIN: op_str = LSD_PIN;
            OP_POUT: op_str = LSD_POUT;
            default: op_str = LSD_NONE;
        endcase
    end

    // decode group: state, decoded form, immediate, pending prefix
    always_comb begin
        st_d = st_q;
        dec_d = dec_q;
        imm_d = imm_q;
        pend_d = pend_q;
        bad_d = 1'b0;
        case (st_q)
            S_IDLE: begin
                if (take && (byte_data[7:1] == OP_RPT_PFX)) begin
                    pend_d = 1'b1;
                    dec_d.rpt_z = byte_data[0];
                end else if (take) begin
                    pend_d = 1'b0;
                    dec_d.op = LSD_NONE;
                    dec_d.grp = G_PLAIN;
                    dec_d.wide = byte_data[0];
                    dec_d.to_reg = byte_data[1];
                    dec_d.mem = 1'b0;
                    dec_d.acc = 1'b0;
                    dec_d.reg_f = 3'h0;
                    dec_d.rpt = 1'b0;
                    st_d = S_MODRM;
                    if (byte_data[7:2] == OP_AND_RM) begin
                        dec_d.op = LSD_AND;
                    end else if (byte_data[7:2] == OP_OR_RM) begin
                        dec_d.op = LSD_OR;
                    end else if (byte_data[7:2] == OP_XOR_RM) begin
                        dec_d.op = LSD_XOR;
                    end else if (byte_data[7:1] == OP_TEST_RM) begin
                        dec_d.op = LSD_TEST;
                    end else if (byte_data[7:1] == OP_GRP3) begin
                        dec_d.grp = G_GRP3;
                    end else if (byte_data[7:1] == OP_IMM_RM) begin
                        dec_d.grp = G_IMM;
                    end else if (byte_data[7:1] == OP_TEST_ACC) begin
                        dec_d.op = LSD_TEST;
                        dec_d.acc = 1'b1;
                        st_d = S_IMM_LO;
                    end else if (op_str != LSD_NONE) begin
                        dec_d.op = op_str;
                        dec_d.mem = 1'b1;
                        dec_d.rpt = pend_q;
                        st_d = pend_q ? S_OVH : S_ELEM;
                    end else begin
                        bad_d = 1'b1;
                        st_d = S_IDLE;
                    end
                end
            end
            S_MODRM: begin
                if (take) begin
                    dec_d.mem = (byte_data[7:6] != MOD_REG);
                    dec_d.reg_f = byte_data[5:3];
                    st_d = S_EXEC;
                    if (dec_q.grp == G_GRP3) begin
                        if (byte_data[5:3] == RF_TEST) begin
                            dec_d.op = LSD_TEST;
                            st_d = S_IMM_LO;
                        end else if (byte_data[5:3] == RF_NOT) begin
                            dec_d.op = LSD_NOT;
                        end else begin
                            bad_d = 1'b1;
                            st_d = S_IDLE;
                        end
                    end else if (dec_q.grp == G_IMM) begin
                        st_d = S_IMM_LO;
                        case (byte_data[5:3])
                            RF_AND: dec_d.op = LSD_AND;
                            RF_OR: dec_d.op = LSD_OR;
                            RF_XOR: dec_d.op = LSD_XOR;
                            default: begin
                                bad_d = 1'b1;
                                st_d = S_IDLE;
                            end
                        endcase
                    end
                end
            end
            S_IMM_LO: begin
                if (take) begin
                    imm_d = {8'h00, byte_data};
                    st_d = dec_q.wide ? S_IMM_HI : S_EXEC;
                end
            end
            S_IMM_HI: begin
                if (take) begin
                    imm_d[15:8] = byte_data;
                    st_d = S_EXEC;
                end
            end
            S_EXEC: begin
                if (cnt_q == CNT_ONE) begin
                    st_d = S_IDLE;
                end
            end
            S_OVH: begin
                if (cnt_q == CNT_ONE) begin
                    st_d = (count_q == 16'h0000) ? S_IDLE : S_ELEM;
                end
            end
            S_ELEM: begin
                if (elem_end && last) begin
                    st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= S_IDLE;
            dec_q <= '0;
            imm_q <= 16'h0000;
            pend_q <= 1'b0;
            bad_op_q <= 1'b0;
        end else begin
            st_q <= st_d;
            dec_q <= dec_d;
            imm_q <= imm_d;
            pend_q <= pend_d;
            bad_op_q <= bad_d;
        end
    end

    // timing group: cycle counter, string pointers, count, strobes
    always_comb begin
        uses_src = (dec_q.op == LSD_MOVE) || (dec_q.op == LSD_CMP) ||
                   (dec_q.op == LSD_LOAD) || (dec_q.op == LSD_POUT);
        uses_dst = (dec_q.op == LSD_MOVE) || (dec_q.op == LSD_CMP) ||
                   (dec_q.op == LSD_SCAN) || (dec_q.op == LSD_STORE) ||
                   (dec_q.op == LSD_PIN);
        step = dec_q.wide ? STEP_W : STEP_B;
        cnt_d = (cnt_q != 8'h00) ? 8'(cnt_q - CNT_ONE) : 8'h00;
        src_d = src_q;
        dst_d = dst_q;
        count_d = count_q;
        elem_d = elem_end;
        if ((st_d == S_EXEC && st_q != S_EXEC) || (st_d == S_OVH && st_q != S_OVH)) begin
            cnt_d = cost.ovh;
        end else if (st_d == S_ELEM && (st_q != S_ELEM || cnt_q == CNT_ONE)) begin
            cnt_d = cost.elem;
        end
        if (st_q == S_IDLE && (st_d == S_OVH || st_d == S_ELEM)) begin
            src_d = src_in;
            dst_d = dst_in;
            count_d = pend_q ? count_in : 16'h0001;
        end else if (elem_end) begin
            if (uses_src) begin
                src_d = dir_flag ? 16'(src_q - step) : 16'(src_q + step);
            end
            if (uses_dst) begin
                dst_d = dir_flag ? 16'(dst_q - step) : 16'(dst_q + step);
            end
            count_d = 16'(count_q - 16'h0001);
        end
        busy_d = (st_d == S_EXEC) || (st_d == S_OVH) || (st_d == S_ELEM);
        done_d = ((st_q == S_EXEC) || (st_q == S_OVH) || (st_q == S_ELEM)) && (st_d == S_IDLE);
        wr_d = done_d && ((dec_q.op == LSD_AND) || (dec_q.op == LSD_OR) ||
                          (dec_q.op == LSD_XOR) || (dec_q.op == LSD_NOT));
        flg_d = (done_d && ((dec_q.op == LSD_AND) || (dec_q.op == LSD_OR) ||
                            (dec_q.op == LSD_XOR) || (dec_q.op == LSD_TEST))) ||
                (elem_end && cmp_scan);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            src_q <= 16'h0000;
            dst_q <= 16'h0000;
            count_q <= 16'h0000;
            busy_q <= 1'b0;
            byte_ready_q <= 1'b1;
            done_q <= 1'b0;
            wr_back_q <= 1'b0;
            flags_upd_q <= 1'b0;
            elem_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            src_q <= src_d;
            dst_q <= dst_d;
            count_q <= count_d;
            busy_q <= busy_d;
            byte_ready_q <= !busy_d;
            done_q <= done_d;
            wr_back_q <= wr_d;
            flags_upd_q <= flg_d;
            elem_q <= elem_d;
        end
    end

    a_logic_reg_cost: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == S_MODRM && take && dec_q.grp == G_PLAIN && dec_q.op == LSD_AND &&
         byte_data[7:6] == MOD_REG) |=> (st_q == S_EXEC && cnt_q == CY_LOG_REG))
        else $error("register and form not charged 3 cycles");

    a_test_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == S_EXEC && cnt_q == CNT_ONE && dec_q.op == LSD_TEST)
        |=> (done_q && flags_upd_q && !wr_back_q))
        else $error("test wrote a result or skipped flags");

    a_test_imm_mem: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == S_IMM_LO && take && dec_q.op == LSD_TEST && dec_q.grp == G_GRP3 &&
         dec_q.mem && !dec_q.wide) |=> (st_q == S_EXEC && cnt_q == CY_TI_MEM))
        else $error("immediate test on memory not 10 cycles");

    a_acc_word_cost: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == S_IMM_HI && take && dec_q.acc) |=> (cnt_q == CY_ACC_W) ##4 done_q)
        else $error("accumulator word test not 4 cycles");

    a_word_surcharge: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == S_MODRM && take && dec_q.grp == G_PLAIN && dec_q.op == LSD_XOR &&
         dec_q.wide && narrow_s && byte_data[7:6] != MOD_REG)
        |=> (cnt_q == 8'(CY_LOG_MEM + CY_WORD_XFER + CY_WORD_XFER)))
        else $error("word memory form missing transfer surcharge");

    a_move_elem_len: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == S_IDLE && take && byte_data[7:1] == OP_MOVE && !byte_data[0] && !pend_q)
        |=> (st_q == S_ELEM && cnt_q == CY_MOVE) ##14 done_q)
        else $error("single byte move not 14 cycles");

    a_rpt_count_dec: assert property (@(posedge core_clk) disable iff (!rst_n)
        (elem_end && dec_q.rpt) |=> (count_q == 16'($past(count_q) - 16'h0001)))
        else $error("repeat count not decremented per element");

    a_rpt_stop_cond: assert property (@(posedge core_clk) disable iff (!rst_n)
        (elem_end && dec_q.rpt && cmp_scan && equal_in != dec_q.rpt_z)
        |=> (st_q == S_IDLE && done_q))
        else $error("repeated compare did not stop on condition");

    a_ptr_step_dn: assert property (@(posedge core_clk) disable iff (!rst_n)
        (elem_end && dec_q.op == LSD_MOVE && dec_q.wide && dir_flag)
        |=> (src_q == 16'($past(src_q) - STEP_W) && dst_q == 16'($past(dst_q) - STEP_W)))
        else $error("word move pointers not stepped down by two");

    a_invert_write_back: assert property (@(posedge core_clk) disable iff (!rst_n)
        (st_q == S_EXEC && cnt_q == CNT_ONE && dec_q.op == LSD_NOT)
        |=> (done_q && wr_back_q && !flags_upd_q))
        else $error("invert did not write back its result");

endmodule

// File: rtl/lsd_pkg.sv
// constants, types and encodings shared by the logic/string decoder
// assumes one core clock; opcode bytes arrive from fetch logic on that clock
// Overview of operation
// - 001000dw/000010dw/001100dw decode and/or/xor with addressing byte, 3 or 10 cycles
// - 1000010w tests register/memory against register, flags only, no result written
// - 1111011w reg 000 tests immediate against operand, one/two data bytes, 4/10
// - 1010100w tests accumulator byte or word against immediate, 3 or 4 cycles
// - byte-wide bus adds 4 cycles per memory transfer on word operations
// - byte-wide bus charges byte figures as base before any word surcharge
// - 1010010w moves one string element, byte or word, 14 cycles
// - 1010011w compares source and destination elements, sets flags, 22 cycles
// - 1010111w scans destination against accumulator, sets flags, 15 cycles
// - 1010110w loads element into accumulator low byte or word, 12 cycles
// - 1010101w stores accumulator low byte or word to destination, 10 cycles
// - 0110110w reads data-register port into destination, 14 cycles
// - 0110111w writes source element to data-register port, 14 cycles
// - repeat prefix repeats string operation count-register times
// - repeated move/input 8+8n, load 6+11n, store 6+9n cycles
// - prefix low bit picks while-equal or while-unequal; compare 5+22n, scan 5+15n
package lsd_pkg;
    localparam logic [5:0] OP_AND_RM = 6'h08;
    localparam logic [5:0] OP_OR_RM = 6'h02;
    localparam logic [5:0] OP_XOR_RM = 6'h0C;
    localparam logic [6:0] OP_TEST_RM = 7'h42;
    localparam logic [6:0] OP_GRP3 = 7'h7B;
    localparam logic [6:0] OP_IMM_RM = 7'h40;
    localparam logic [6:0] OP_TEST_ACC = 7'h54;
    localparam logic [6:0] OP_MOVE = 7'h52;
    localparam logic [6:0] OP_CMP = 7'h53;
    localparam logic [6:0] OP_SCAN = 7'h57;
    localparam logic [6:0] OP_LOAD = 7'h56;
    localparam logic [6:0] OP_STORE = 7'h55;
    localparam logic [6:0] OP_PIN = 7'h36;
    localparam logic [6:0] OP_POUT = 7'h37;
    localparam logic [6:0] OP_RPT_PFX = 7'h79;
    localparam logic [2:0] RF_TEST = 3'h0;
    localparam logic [2:0] RF_NOT = 3'h2;
    localparam logic [2:0] RF_AND = 3'h4;
    localparam logic [2:0] RF_OR = 3'h1;
    localparam logic [2:0] RF_XOR = 3'h6;
    localparam logic [1:0] MOD_REG = 2'h3;
    localparam logic [7:0] CY_LOG_REG = 8'h03;
    localparam logic [7:0] CY_LOG_MEM = 8'h0A;
    localparam logic [7:0] CY_IMM_REG = 8'h04;
    localparam logic [7:0] CY_IMM_MEM = 8'h10;
    localparam logic [7:0] CY_TI_REG = 8'h04;
    localparam logic [7:0] CY_TI_MEM = 8'h0A;
    localparam logic [7:0] CY_ACC_B = 8'h03;
    localparam logic [7:0] CY_ACC_W = 8'h04;
    localparam logic [7:0] CY_MOVE = 8'h0E;
    localparam logic [7:0] CY_CMP = 8'h16;
    localparam logic [7:0] CY_SCAN = 8'h0F;
    localparam logic [7:0] CY_LOAD = 8'h0C;
    localparam logic [7:0] CY_STORE = 8'h0A;
    localparam logic [7:0] CY_PORT = 8'h0E;
    localparam logic [7:0] CY_RMOV_O = 8'h08;
    localparam logic [7:0] CY_RMOV_E = 8'h08;
    localparam logic [7:0] CY_RLD_O = 8'h06;
    localparam logic [7:0] CY_RLD_E = 8'h0B;
    localparam logic [7:0] CY_RST_O = 8'h06;
    localparam logic [7:0] CY_RST_E = 8'h09;
    localparam logic [7:0] CY_RCMP_O = 8'h05;
    localparam logic [7:0] CY_RCMP_E = 8'h16;
    localparam logic [7:0] CY_RSCN_O = 8'h05;
    localparam logic [7:0] CY_RSCN_E = 8'h0F;
    localparam logic [7:0] CY_WORD_XFER = 8'h04;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [15:0] STEP_B = 16'h0001;
    localparam logic [15:0] STEP_W = 16'h0002;
    typedef enum logic [3:0] {
        LSD_NONE = 4'h0, LSD_AND = 4'h1, LSD_OR = 4'h2, LSD_XOR = 4'h3,
        LSD_TEST = 4'h4, LSD_NOT = 4'h5, LSD_MOVE = 4'h6, LSD_CMP = 4'h7,
        LSD_SCAN = 4'h8, LSD_LOAD = 4'h9, LSD_STORE = 4'hA, LSD_PIN = 4'hB,
        LSD_POUT = 4'hC
    } lsd_op_t;
    typedef enum logic [1:0] {G_PLAIN = 2'h0, G_GRP3 = 2'h1, G_IMM = 2'h2} lsd_grp_t;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_MODRM = 3'h1, S_IMM_LO = 3'h2, S_IMM_HI = 3'h3,
        S_EXEC = 3'h4, S_OVH = 3'h5, S_ELEM = 3'h6
    } lsd_state_t;
    typedef struct packed {
        lsd_op_t op;
        lsd_grp_t grp;
        logic wide;
        logic to_reg;
        logic mem;
        logic acc;
        logic [2:0] reg_f;
        logic rpt;
        logic rpt_z;
    } lsd_dec_t;
    typedef struct packed {
        logic [7:0] ovh;
        logic [7:0] elem;
    } lsd_cost_t;
endpackage

// File: rtl/lsd_sync2.sv
// two-stage synchroniser for one level from a pin
// assumes the level changes slowly against core_clk
`timescale 1ns/1ps
module lsd_sync2 (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic level_q
);
    logic meta_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            level_q <= meta_q;
        end
    end
endmodule

// File: verif/lsd_decoder_tb.sv
// self-checking bench for the logic/string decoder
// assumes the fetch model feeds bytes; strap, flags and pointers driven here
`timescale 1ns/1ps
module lsd_decoder_tb;
    import lsd_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic narrow_bus_pin = 1'b0;
    logic dir_flag = 1'b0;
    logic equal_in = 1'b0;
    logic [15:0] count_in = 16'h0000;
    logic [15:0] src_in = 16'h1000;
    logic [15:0] dst_in = 16'h2000;
    logic byte_valid, byte_ready_q, busy_q, done_q, wr_back_q, flags_upd_q, elem_q, bad_op_q;
    logic [7:0] byte_data;
    logic [15:0] imm_q, src_q, dst_q, count_q, cyc, elems;
    lsd_dec_t dec_q;
    logic wr_seen, fl_seen, bad_seen;
    int failures = 0;
    int num_checks = 0;
    int ticks = 0;
    always #25 core_clk = ~core_clk;
    lsd_fetch_model u_lsd_fetch_model (.core_clk(core_clk), .rst_n(rst_n),
        .byte_ready_q(byte_ready_q), .byte_valid(byte_valid), .byte_data(byte_data));
    lsd_decoder u_lsd_decoder (.core_clk(core_clk), .rst_n(rst_n), .byte_valid(byte_valid),
        .byte_data(byte_data), .narrow_bus_pin(narrow_bus_pin), .dir_flag(dir_flag),
        .equal_in(equal_in), .count_in(count_in), .src_in(src_in), .dst_in(dst_in),
        .byte_ready_q(byte_ready_q), .dec_q(dec_q), .imm_q(imm_q), .busy_q(busy_q),
        .done_q(done_q), .wr_back_q(wr_back_q), .flags_upd_q(flags_upd_q), .elem_q(elem_q),
        .bad_op_q(bad_op_q), .src_q(src_q), .dst_q(dst_q), .count_q(count_q));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // feeds nb bytes, counts busy cycles and pulses until done or refusal
    task automatic run(input logic [31:0] b, input int nb);
        {wr_seen, fl_seen, bad_seen} = 3'b000;
        cyc = 16'h0000;
        elems = 16'h0000;
        for (int i = nb - 1; i >= 0; i--) u_lsd_fetch_model.push(b[i*8 +: 8]);
        for (int t = 0; t < 400; t++) begin
            @(negedge core_clk);
            if (busy_q === 1'b1) cyc++;
            if (elem_q === 1'b1) elems++;
            if (wr_back_q === 1'b1) wr_seen = 1'b1;
            if (flags_upd_q === 1'b1) fl_seen = 1'b1;
            if (bad_op_q === 1'b1) bad_seen = 1'b1;
            if (done_q === 1'b1 || bad_seen) break;
        end
        if (done_q !== 1'b1 && !bad_seen) begin
            failures++;
            $display("[ERR] done expected 1 seen %b", done_q);
        end
    endtask
    task automatic form(input logic [31:0] b, input int nb, input int cy, input lsd_op_t op,
        input logic wr, input logic fl);
        run(b, nb);
        chk("cycles", 16'(cy), cyc);
        chk("op", {12'h000, op}, {12'h000, dec_q.op});
        chk("wr_back", {15'h0000, wr}, {15'h0000, wr_seen});
        chk("flags", {15'h0000, fl}, {15'h0000, fl_seen});
        chk("ready", 16'h0001, {15'h0000, byte_ready_q});
    endtask
    task automatic t_logic();
        form(32'h20C0, 2, 3, LSD_AND, 1'b1, 1'b1);
        form(32'h3007, 2, 10, LSD_XOR, 1'b1, 1'b1);
        chk("mem", 16'h0001, {15'h0000, dec_q.mem});
        form(32'h81C83412, 4, 4, LSD_OR, 1'b1, 1'b1);
        chk("imm", 16'h1234, imm_q);
        form(32'hF6D0, 2, 3, LSD_NOT, 1'b1, 1'b0);
        $display("done: logic");
    endtask
    task automatic t_test();
        form(32'h85C1, 2, 3, LSD_TEST, 1'b0, 1'b1);
        form(32'hF7C03412, 4, 4, LSD_TEST, 1'b0, 1'b1);
        chk("imm", 16'h1234, imm_q);
        form(32'hF607AA, 3, 10, LSD_TEST, 1'b0, 1'b1);
        form(32'hA855, 2, 3, LSD_TEST, 1'b0, 1'b1);
        form(32'hA93412, 3, 4, LSD_TEST, 1'b0, 1'b1);
        run(32'hF6C8, 2);
        chk("bad_op", 16'h0001, {15'h0000, bad_seen});
        $display("done: test");
    endtask
    task automatic t_narrow();
        narrow_bus_pin = 1'b1;
        repeat (3) @(negedge core_clk);
        form(32'h3307, 2, 18, LSD_XOR, 1'b1, 1'b1);
        form(32'h0A07, 2, 10, LSD_OR, 1'b1, 1'b1);
        form(32'hA5, 1, 22, LSD_MOVE, 1'b0, 1'b0);
        narrow_bus_pin = 1'b0;
        repeat (3) @(negedge core_clk);
        $display("done: narrow");
    endtask
    task automatic t_strings();
        form(32'hA4, 1, 14, LSD_MOVE, 1'b0, 1'b0);
        form(32'hA6, 1, 22, LSD_CMP, 1'b0, 1'b1);
        form(32'hAE, 1, 15, LSD_SCAN, 1'b0, 1'b1);
        form(32'hAC, 1, 12, LSD_LOAD, 1'b0, 1'b0);
        form(32'hAA, 1, 10, LSD_STORE, 1'b0, 1'b0);
        form(32'h6C, 1, 14, LSD_PIN, 1'b0, 1'b0);
        form(32'h6E, 1, 14, LSD_POUT, 1'b0, 1'b0);
        run(32'hA4, 1);
        chk("src", 16'h1001, src_q);
        chk("dst", 16'h2001, dst_q);
        $display("done: strings");
    endtask
    task automatic t_repeat();
        dir_flag = 1'b1;
        count_in = 16'h0002;
        form(32'hF2A5, 2, 24, LSD_MOVE, 1'b0, 1'b0);
        chk("src", 16'h0FFC, src_q);
        chk("dst", 16'h1FFC, dst_q);
        chk("count", 16'h0000, count_q);
        chk("elems", 16'h0002, elems);
        dir_flag = 1'b0;
        equal_in = 1'b1;
        form(32'hF3A6, 2, 49, LSD_CMP, 1'b0, 1'b1);
        chk("rpt_z", 16'h0001, {15'h0000, dec_q.rpt_z});
        form(32'hF2AE, 2, 20, LSD_SCAN, 1'b0, 1'b1);
        form(32'hF2AC, 2, 28, LSD_LOAD, 1'b0, 1'b0);
        form(32'hF2AA, 2, 24, LSD_STORE, 1'b0, 1'b0);
        $display("done: repeat");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        ticks++;
        if (ticks > 5000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        t_logic();
        t_test();
        t_narrow();
        t_strings();
        t_repeat();
        print_verdict();
    end
endmodule

// File: verif/lsd_fetch_model.sv
// fetch-side model: feeds queued instruction bytes to the decoder
// assumes a byte is taken at a rising edge with valid and ready high
`timescale 1ns/1ps
module lsd_fetch_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic byte_ready_q,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    logic [7:0] q[$];
    logic took = 1'b0;
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'hA5;
    end
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask
    always @(posedge core_clk) took <= byte_valid && byte_ready_q && rst_n;
    // idle bus inverts the shown byte each cycle, alternating between the last byte and its inverse
    always @(negedge core_clk) begin
        if (took) void'(q.pop_front());
        byte_valid = q.size() > 0;
        byte_data = (q.size() > 0) ? q[0] : ~byte_data;
    end
endmodule
